// ==== irq_enable_priority_slice.sv ====
// Interrupt enable bank two, priority banks zero to two, APB register slave
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "irq_slice_params.svh"
module irq_enable_priority_slice (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`IRQS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`IRQS_SRC_A-1:0] eventA,
	input wire irq_slice_pkg::level_t [`IRQS_SRC_A-1:0] extLevelA,
	input wire logic [`IRQS_SRC_B-1:0] eventB,
	input wire logic [`IRQS_SRC_B-1:0] extEnableB,
	output irq_slice_pkg::core_req_s [`IRQS_SRC_A-1:0] coreReqA,
	output irq_slice_pkg::core_req_s [`IRQS_SRC_B-1:0] coreReqB,
	output logic irq
);
	logic [`IRQS_ENABLE_W-1:0] enable_reg;
	logic [`IRQS_ENABLE_W-1:0] enable_next;
	logic [`IRQS_STAT_W-1:0] flag_reg;
	logic [`IRQS_STAT_W-1:0] flag_next;
	logic [`IRQS_STAT_W-1:0] mask_reg;
	logic [`IRQS_STAT_W-1:0] mask_next;
	logic [31:0] prdata_next;
	logic pready_next;
	logic pslverr_next;
	logic irq_next;
	irq_slice_pkg::core_req_s [`IRQS_SRC_A-1:0] coreReqA_next;
	irq_slice_pkg::core_req_s [`IRQS_SRC_B-1:0] coreReqB_next;

	logic access;
	logic wrDone;
	logic rdDone;
	logic hitEnable;
	logic hitStatus;
	logic hitMask;
	logic [`IRQS_PRIO_BANKS-1:0] hitPrio;
	logic mapped;
	logic [31:0] readMux;
	logic [`IRQS_STAT_W-1:0] statusClear;
	logic [`IRQS_STAT_W-1:0] eventAll;
	logic [`IRQS_SRC_A-1:0] reqSeenA;
	logic [`IRQS_SRC_B-1:0] reqSeenB;

	logic [15:0] bankValue [`IRQS_PRIO_BANKS];
	irq_slice_pkg::level_t [3:0] bankLevels [`IRQS_PRIO_BANKS];
	irq_slice_pkg::level_t [`IRQS_SRC_B-1:0] levelB;

	// Bus decode: the access phase always lasts two cycles
	assign access = psel & penable;
	assign wrDone = access & pready & pwrite;
	assign rdDone = access & pready & ~pwrite;
	assign hitEnable = (paddr == `IRQS_OFF_ENABLE);
	assign hitPrio[0] = (paddr == `IRQS_OFF_PRIO0);
	assign hitPrio[1] = (paddr == `IRQS_OFF_PRIO1);
	assign hitPrio[2] = (paddr == `IRQS_OFF_PRIO2);
	assign hitStatus = (paddr == `IRQS_OFF_STATUS);
	assign hitMask = (paddr == `IRQS_OFF_MASK);
	assign mapped = hitEnable | (|hitPrio) | hitStatus | hitMask;
	assign eventAll = {eventB, eventA};

	always_comb begin
		readMux = 32'h0;
		unique case (1'b1)
			hitEnable: readMux = {19'h0, enable_reg};
			hitPrio[0]: readMux = {16'h0, bankValue[0]};
			hitPrio[1]: readMux = {16'h0, bankValue[1]};
			hitPrio[2]: readMux = {16'h0, bankValue[2]};
			hitStatus: readMux = {7'h0, flag_reg};
			hitMask: readMux = {7'h0, mask_reg};
			default: readMux = 32'h0;
		endcase
	end

	always_comb begin
		pready_next = access & ~pready;
		prdata_next = 32'h0;
		pslverr_next = 1'b0;
		// Data are captured one cycle ahead so prdata comes from a flop
		if (access && !pready) begin
			prdata_next = pwrite ? 32'h0 : readMux;
			pslverr_next = ~mapped;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	// Only bits already returned on prdata are cleared, so a flag raised
	// after the snapshot survives the read
	assign statusClear = (rdDone && hitStatus) ?
		prdata[`IRQS_STAT_W-1:0] : `IRQS_RST_STAT;

	always_comb begin
		enable_next = enable_reg;
		mask_next = mask_reg;
		if (wrDone && hitEnable) begin
			enable_next = pwdata[`IRQS_ENABLE_W-1:0];
		end
		if (wrDone && hitMask) begin
			mask_next = pwdata[`IRQS_STAT_W-1:0];
		end
		flag_next = (flag_reg & ~statusClear) | eventAll;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable_reg <= `IRQS_RST_ENABLE;
			mask_reg <= `IRQS_RST_STAT;
			flag_reg <= `IRQS_RST_STAT;
		end else begin
			enable_reg <= enable_next;
			mask_reg <= mask_next;
			flag_reg <= flag_next;
		end
	end

	genvar b;
	generate
		for (b = 0; b < `IRQS_PRIO_BANKS; b++) begin : g_bank
			irq_prio_reg u_prio (
				.clk(clk),
				.sys_rst(sys_rst),
				.wrEn(wrDone & hitPrio[b]),
				.wrData(pwdata[15:0]),
				.value(bankValue[b]),
				.levels(bankLevels[b])
			);
		end
	endgenerate

	// Bank b field f serves source index 4*b+f of group B
	genvar s;
	generate
		for (s = 0; s < `IRQS_SRC_B; s++) begin : g_lvl
			assign levelB[s] = bankLevels[s/4][s%4];
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < `IRQS_SRC_A; i++) begin : g_req_a
			assign coreReqA_next[i].req = flag_reg[i] & enable_reg[i];
			assign coreReqA_next[i].level = extLevelA[i];
			assign reqSeenA[i] = coreReqA[i].req;
		end
		for (i = 0; i < `IRQS_SRC_B; i++) begin : g_req_b
			assign coreReqB_next[i].req =
				flag_reg[`IRQS_SRC_A+i] & extEnableB[i];
			assign coreReqB_next[i].level = levelB[i];
			assign reqSeenB[i] = coreReqB[i].req;
		end
	endgenerate

	assign irq_next = |(flag_reg & mask_reg);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			coreReqA <= '0;
			coreReqB <= '0;
			irq <= 1'b0;
		end else begin
			coreReqA <= coreReqA_next;
			coreReqB <= coreReqB_next;
			irq <= irq_next;
		end
	end

	a_ready_pulse: assert property (
		@(posedge clk) disable iff (sys_rst)
		pready |=> !pready)
		else $error("ready held past one cycle");

	a_err_unmapped: assert property (
		@(posedge clk) disable iff (sys_rst)
		(pready && !mapped) |-> pslverr)
		else $error("unmapped access without slave error");

	a_rdata_idle: assert property (
		@(posedge clk) disable iff (sys_rst)
		!pready |-> (prdata == 32'h0))
		else $error("read data outside the answer cycle");

	a_enable_blocks: assert property (
		@(posedge clk) disable iff (sys_rst)
		(enable_reg == 13'h0000) |=> (reqSeenA == 13'h0000))
		else $error("request passed a cleared enable");

	a_enable_gaps: assert property (
		@(posedge clk) disable iff (sys_rst)
		(rdDone && hitEnable) |-> ((prdata & `IRQS_ENABLE_GAPS) == 32'h0))
		else $error("enable register upper bits not zero");

	a_enable_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitEnable) |=> (enable_reg == $past(pwdata[12:0])))
		else $error("enable write not stored");

	a_enable_hold: assert property (
		@(posedge clk) disable iff (sys_rst)
		!(wrDone && hitEnable) |=> $stable(enable_reg))
		else $error("enable bank changed without a write");

	a_fault_b_bit: assert property (
		@(posedge clk) disable iff (sys_rst)
		(flag_reg[12] && enable_reg[12]) |=> reqSeenA[12])
		else $error("fault B enable does not pass request");

	a_fault_b_block: assert property (
		@(posedge clk) disable iff (sys_rst)
		!enable_reg[12] |=> !reqSeenA[12])
		else $error("fault B request passed a cleared enable");

	a_pwm_bit: assert property (
		@(posedge clk) disable iff (sys_rst)
		(flag_reg[7] && enable_reg[7]) |=> reqSeenA[7])
		else $error("motor PWM enable does not pass request");

	a_pwm_block: assert property (
		@(posedge clk) disable iff (sys_rst)
		!enable_reg[7] |=> !reqSeenA[7])
		else $error("motor PWM request passed a cleared enable");

	a_compare5_bit: assert property (
		@(posedge clk) disable iff (sys_rst)
		(flag_reg[0] && enable_reg[0]) |=> reqSeenA[0])
		else $error("compare 5 enable does not pass request");

	a_level_full: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[0] && pwdata[15:0] == 16'hffff)
		|=> (bankValue[0] == 16'h7777))
		else $error("priority fields not seven at full write");

	a_prio_gaps: assert property (
		@(posedge clk) disable iff (sys_rst)
		(rdDone && hitPrio != 3'b000)
		|-> ((prdata & `IRQS_PRIO_GAPS) == 32'h0))
		else $error("priority gap bits not zero");

	a_prio_write1: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[1])
		|=> (bankValue[1] == ($past(pwdata[15:0]) & `IRQS_PRIO_MASK)))
		else $error("priority bank one write not stored");

	a_prio_hold0: assert property (
		@(posedge clk) disable iff (sys_rst)
		!(wrDone && hitPrio[0]) |=> $stable(bankValue[0]))
		else $error("priority bank zero changed without a write");

	a_timer1_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[0]) |=> (levelB[3] == $past(pwdata[14:12])))
		else $error("timer1 level misplaced");

	a_ext0_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[0]) |=> (levelB[0] == $past(pwdata[2:0])))
		else $error("ext irq 0 level misplaced");

	a_timer2_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[1]) |=> (levelB[6] == $past(pwdata[10:8])))
		else $error("timer2 level misplaced");

	a_capture2_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[1]) |=> (levelB[4] == $past(pwdata[2:0])))
		else $error("capture 2 level misplaced");

	a_timer3_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[1]) |=> (levelB[7] == $past(pwdata[14:12])))
		else $error("timer3 level misplaced");

	a_spi_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[2]) |=> (levelB[8] == $past(pwdata[2:0])))
		else $error("SPI port level misplaced");

	a_adc_field: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wrDone && hitPrio[2]) |=> (levelB[11] == $past(pwdata[14:12])))
		else $error("converter done level misplaced");

	a_event_sets: assert property (
		@(posedge clk) disable iff (sys_rst)
		(eventAll != 25'h0)
		|=> ((flag_reg & $past(eventAll)) == $past(eventAll)))
		else $error("event lost from request flag");

	a_status_clear: assert property (
		@(posedge clk) disable iff (sys_rst)
		(rdDone && hitStatus) |=> ((flag_reg
		& $past(prdata[`IRQS_STAT_W-1:0]) & ~$past(eventAll)) == 25'h0))
		else $error("read bits not cleared from status");

	a_flag_sticky: assert property (
		@(posedge clk) disable iff (sys_rst)
		!(rdDone && hitStatus)
		|=> ((flag_reg & $past(flag_reg)) == $past(flag_reg)))
		else $error("request flag dropped without a status read");

	a_flag_source: assert property (
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> ((flag_reg & ~$past(flag_reg) & ~$past(eventAll))
		== 25'h0))
		else $error("request flag rose without an event");

	a_reset_clear: assert property (
		@(posedge clk)
		sys_rst |=> (enable_reg == 13'h0000 && bankValue[0] == 16'h0000
		&& bankValue[1] == 16'h0000 && bankValue[2] == 16'h0000))
		else $error("reset left enable or priority set");

	a_reset_outputs: assert property (
		@(posedge clk)
		sys_rst |=> (prdata == 32'h0 && !pready && !pslverr && !irq
		&& coreReqA == '0 && coreReqB == '0 && flag_reg == 25'h0))
		else $error("reset left an output or flag set");

	a_req_level: assert property (
		@(posedge clk) disable iff (sys_rst)
		(flag_reg[24] && extEnableB[11])
		|=> (reqSeenB[11] && coreReqB[11].level == $past(levelB[11])))
		else $error("qualified request or level wrong");

	a_level_pass_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> (coreReqA[3].level == $past(extLevelA[3])))
		else $error("group A level not forwarded");
endmodule : irq_enable_priority_slice

// ==== irq_slice_params.svh ====
// Register offsets, field positions and reset values of the enable/priority slice
`ifndef IRQ_SLICE_PARAMS_SVH
`define IRQ_SLICE_PARAMS_SVH

`define IRQS_ADDR_W 8
`define IRQS_OFF_ENABLE 8'h00
`define IRQS_OFF_PRIO0 8'h04
`define IRQS_OFF_PRIO1 8'h08
`define IRQS_OFF_PRIO2 8'h0c
`define IRQS_OFF_STATUS 8'h10
`define IRQS_OFF_MASK 8'h14

`define IRQS_ENABLE_W 13
`define IRQS_SRC_A 13
`define IRQS_SRC_B 12
`define IRQS_STAT_W 25
`define IRQS_PRIO_BANKS 3
`define IRQS_FIELDS 4
`define IRQS_FIELD_W 3
`define IRQS_FIELD_STRIDE 4

`define IRQS_RST_ENABLE 13'h0000
`define IRQS_RST_PRIO 16'h0000
`define IRQS_RST_STAT 25'h0000000
`define IRQS_PRIO_MASK 16'h7777
`define IRQS_PRIO_GAPS 32'hffff8888
`define IRQS_ENABLE_GAPS 32'hffffe000

`endif

// ==== irq_slice_pkg.sv ====
// Types shared by the enable/priority slice
package irq_slice_pkg;
	typedef logic [2:0] level_t;

	typedef struct packed {
		logic req;
		level_t level;
	} core_req_s;
endpackage : irq_slice_pkg

// ==== irq_prio_reg.sv ====
// One priority register holding four 3-bit level fields
`timescale 1ns/1ps
`include "irq_slice_params.svh"
module irq_prio_reg (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wrEn,
	input wire logic [15:0] wrData,
	output logic [15:0] value,
	output irq_slice_pkg::level_t [3:0] levels
);
	logic [15:0] value_reg;
	logic [15:0] value_next;

	always_comb begin
		value_next = value_reg;
		// Gap bits are dropped so they always read back as zero
		if (wrEn) begin
			value_next = wrData & `IRQS_PRIO_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			value_reg <= `IRQS_RST_PRIO;
		end else begin
			value_reg <= value_next;
		end
	end

	assign value = value_reg;

	genvar f;
	generate
		for (f = 0; f < `IRQS_FIELDS; f++) begin : g_field
			assign levels[f] =
				value_reg[f*`IRQS_FIELD_STRIDE +: `IRQS_FIELD_W];
		end
	endgenerate
endmodule : irq_prio_reg

// ==== irq_source_model.sv ====
// Peripheral source model: fires one-cycle event pulses on request
`timescale 1ns/1ps
module irq_source_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [12:0] selA,
	input wire logic [11:0] selB,
	output logic [12:0] eventA,
	output logic [11:0] eventB
);
	// One-cycle pulses, so a held request cannot hide a cleared flag
	always_ff @(posedge clk) begin
		eventA <= go ? selA : 13'h0000;
		eventB <= go ? selB : 12'h000;
	end
endmodule : irq_source_model

// ==== tb.sv ====
// Self-checking bench for the enable/priority slice
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, en, msk;
	logic pready, pslverr, irq, err;
	logic go = 1'b0;
	logic [12:0] eventA;
	logic [12:0] selA = 13'h0000;
	logic [11:0] eventB;
	logic [11:0] selB = 12'h000;
	logic [11:0] extEnableB = 12'h000;
	irq_slice_pkg::level_t [12:0] extLevelA = '0;
	irq_slice_pkg::core_req_s [12:0] coreReqA;
	irq_slice_pkg::core_req_s [11:0] coreReqB;
	logic [15:0] prio [3];
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int seed = 32'h504f;

	always #5 clk = ~clk;

	irq_enable_priority_slice u_irq_enable_priority_slice (.clk(clk),
		.sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .eventA(eventA), .extLevelA(extLevelA),
		.eventB(eventB), .extEnableB(extEnableB), .coreReqA(coreReqA),
		.coreReqB(coreReqB), .irq(irq));
	irq_source_model u_irq_source_model (.clk(clk), .go(go), .selA(selA),
		.selB(selB), .eventA(eventA), .eventB(eventB));

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Entered just after an edge; holds the request until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	function automatic logic [2:0] lvlB(input int j);
		return prio[j / 4][4 * (j % 4) +: 3];
	endfunction : lvlB

	// Whole run needs well under 3000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a <= 24; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk("reset value", rd, 32'h0);
			chk("slave error", {31'h0, err}, {31'h0, a == 24});
		end
		$display("reset test done");
		for (int r = 0; r < 6; r++) begin
			en = r == 0 ? 32'hffffffff : r == 1 ? 32'h0 : $random(seed);
			msk = r == 5 ? 32'h0 : $random(seed);
			apb(1'b1, 8'h00, en);
			apb(1'b0, 8'h00, 32'h0);
			chk("enable bank", rd, en & 32'h00001fff);
			apb(1'b1, 8'h14, msk);
			for (int b = 0; b < 3; b++) begin
				prio[b] = r == 0 ? 16'hffff : r == 1 ? 16'h0 : 16'($random(seed));
				apb(1'b1, 8'(4 + 4 * b), {16'hffff, prio[b]});
				apb(1'b0, 8'(4 + 4 * b), 32'h0);
				chk("priority bank", rd, {16'h0, prio[b] & 16'h7777});
			end
			// First two rounds fire every source to hit all-on and, for group A enables only, all-off
			selA <= r < 2 ? 13'h1fff : 13'($random(seed));
			selB <= r < 2 ? 12'hfff : 12'($random(seed));
			extEnableB <= r == 0 ? 12'hfff : 12'($random(seed));
			for (int i = 0; i < 13; i++)
				extLevelA[i] <= 3'($random(seed));
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (4) @(posedge clk);
			for (int i = 0; i < 13; i++)
				chk("request A", coreReqA[i], {selA[i] & en[i], extLevelA[i]});
			for (int j = 0; j < 12; j++)
				chk("request B", coreReqB[j], {selB[j] & extEnableB[j], lvlB(j)});
			chk("irq", irq, |({selB, selA} & msk[24:0]));
			apb(1'b0, 8'h10, 32'h0);
			chk("status", rd, {7'h0, selB, selA});
			apb(1'b0, 8'h10, 32'h0);
			chk("status cleared", rd, 32'h0);
			@(posedge clk);
			chk("irq cleared", irq, 1'b0);
			$display("round %0d done", r);
		end
		// Corner: an event landing in the clearing cycle must survive
		selA <= 13'h0081;
		selB <= 12'h801;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
		fork
			apb(1'b0, 8'h10, 32'h0);
			begin
				@(posedge clk);
				go <= 1'b1;
				@(posedge clk);
				go <= 1'b0;
			end
		join
		chk("status snapshot", rd, {7'h0, selB, selA});
		apb(1'b1, 8'h10, 32'hffffffff);
		apb(1'b1, 8'h18, 32'hffffffff);
		chk("unmapped write error", {31'h0, err}, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk("event in clear cycle", rd, {7'h0, selB, selA});
		apb(1'b0, 8'h10, 32'h0);
		chk("status empty", rd, 32'h0);
		$display("corner test done");
		tally_and_finish();
	end
endmodule : tb
